// ==== hw/weld_mode_sequencer.sv ====
`timescale 1ns/10ps
// Notes on behaviour
// - Continuous mode: output follows start input, one clock later.
// - Time mode: output for 0.01 to 30 s.
// - Energy mode: output until 10 to 9999 J.
// - Register 138 holds mode: 0,1,2.
// - Up/down step the selected register number.
// - Config key shows value, lights circle icon.
// - Up/down edit pending; config key commits it at register 138, else just returns.
// - Continuous commit shows mode icon and amplitude.
// - Time/energy shows icon, parameter, editable, committable.
// - Enabled cutoff ends delivery in every mode.
`include "weld_params.svh"
module weld_mode_sequencer
    import weld_pkg::*;
#(
    parameter int TICK_CYCLES = `WM_TICK_CYCLES
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic key_up,
    input wire logic key_down,
    input wire logic key_cfg,
    input wire logic start_in,
    input wire logic cutoff_in,
    input wire logic [15:0] power_w,
    output logic us_on,
    output logic weld_done,
    output logic [13:0] disp_value,
    output logic icon_num,
    output logic icon_circle,
    output logic icon_pct,
    output logic icon_cont,
    output logic icon_time,
    output logic icon_energy
);

    // Limits a value to a closed range.
    function automatic logic [13:0] clamp14(input logic [13:0] v, input logic [13:0] lo,
                                            input logic [13:0] hi);
        if (v < lo) begin
            return lo;
        end else if (v > hi) begin
            return hi;
        end
        return v;
    endfunction

    // True for every offset that the slave answers without error.
    function automatic logic addr_mapped(input logic [7:0] a);
        case (a)
            `WM_OFF_MODE, `WM_OFF_TIME, `WM_OFF_ENERGY, `WM_OFF_AMPL,
            `WM_OFF_STATUS, `WM_OFF_CUTOFF, `WM_OFF_JOULES, `WM_OFF_TICKS: begin
                return 1'b1;
            end
            default: begin
                return 1'b0;
            end
        endcase
    endfunction

    logic [1:0] mode_r; // Committed weld mode.
    logic [13:0] time_r; // Weld time in 10 ms ticks.
    logic [13:0] energy_r; // Energy target in joules.
    logic [13:0] ampl_r; // Amplitude in percent, shown only.
    logic cutoff_en_r; // Lets the cutoff input end a weld.
    panel_state_t pnl_r; // Panel state.
    logic [7:0] sel_r; // Selected panel register number.
    logic [13:0] pend_r; // Pending value under edit.
    weld_state_t ws_r; // Delivery state.
    weld_state_t ws_nxt; // Next delivery state.
    logic [13:0] ticks_r; // Elapsed ticks of the current weld.
    logic [13:0] joules_r; // Joules delivered in the current weld.
    logic [24:0] frac_r; // Sub-joule energy remainder in watt-cycles.
    logic [24:0] frac_sum; // Remainder plus this cycle's power.
    logic tick; // One pulse every 10 ms while welding.
    logic [31:0] rd_mux; // Read data selected by address.
    logic setup_ph; // APB setup phase.
    logic wr_go; // APB write completes this edge.
    logic [1:0] pend_mode; // Pending value as a legal mode code.
    logic mode_commit; // Panel commits register 138 this edge.
    logic param_commit; // Panel commits time or energy this edge.
    logic cut; // Enabled cutoff is active.

    assign setup_ph = psel && !penable;
    assign wr_go = psel && penable && pready && pwrite && addr_mapped(paddr);
    assign pend_mode = (pend_r > 14'h0002) ? `WM_MODE_ENERGY : pend_r[1:0];
    assign mode_commit = (pnl_r == PNL_EDIT) && key_cfg && (sel_r == `WM_REG_MODE);
    assign param_commit = (pnl_r == PNL_PARAM) && key_cfg;
    assign cut = cutoff_en_r && cutoff_in;
    assign frac_sum = frac_r + {9'h000, power_w};

    // The 10 ms time base runs only during delivery.
    weld_tick_gen #(
        .CYCLES(TICK_CYCLES)
    ) u_tick (
        .pclk(pclk),
        .presetn(presetn),
        .run(ws_r == WS_WELD),
        .tick(tick)
    );

    // Read multiplexer; unmapped offsets read as zero.
    always_comb begin
        rd_mux = 32'h00000000;
        case (paddr)
            `WM_OFF_MODE: begin
                rd_mux = {30'h00000000, mode_r};
            end
            `WM_OFF_TIME: begin
                rd_mux = {18'h00000, time_r};
            end
            `WM_OFF_ENERGY: begin
                rd_mux = {18'h00000, energy_r};
            end
            `WM_OFF_AMPL: begin
                rd_mux = {18'h00000, ampl_r};
            end
            `WM_OFF_STATUS: begin
                rd_mux[`WM_ST_ACTIVE] = us_on;
                rd_mux[`WM_ST_DONE] = weld_done;
                rd_mux[`WM_ST_MODE_LO +: 2] = mode_r;
            end
            `WM_OFF_CUTOFF: begin
                rd_mux = {31'h00000000, cutoff_en_r};
            end
            `WM_OFF_JOULES: begin
                rd_mux = {18'h00000, joules_r};
            end
            `WM_OFF_TICKS: begin
                rd_mux = {18'h00000, ticks_r};
            end
            default: begin
                rd_mux = 32'h00000000;
            end
        endcase
    end

    // APB answer: no wait state, so pready rises in the first access cycle.
    // Read data is captured in setup so it is stable across the access phase.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end else begin
            pready <= setup_ph;
            pslverr <= setup_ph && !addr_mapped(paddr);
            if (setup_ph) begin
                prdata <= rd_mux;
            end
        end
    end

    // Settings: panel commits and bus writes; out-of-range values are clamped.
    // A panel commit wins over a bus write on the same edge, as the operator is present.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_r <= `WM_MODE_RST;
            time_r <= `WM_TIME_RST;
            energy_r <= `WM_ENERGY_RST;
            ampl_r <= `WM_AMPL_RST;
            cutoff_en_r <= 1'b0;
        end else if (mode_commit) begin
            mode_r <= pend_mode;
        end else if (param_commit) begin
            if (mode_r == `WM_MODE_TIME) begin
                time_r <= clamp14(pend_r, `WM_TIME_MIN, `WM_TIME_MAX);
            end else begin
                energy_r <= clamp14(pend_r, `WM_ENERGY_MIN, `WM_ENERGY_MAX);
            end
        end else if (wr_go) begin
            case (paddr)
                `WM_OFF_MODE: begin
                    mode_r <= (pwdata[1:0] == 2'h3) ? `WM_MODE_ENERGY : pwdata[1:0];
                end
                `WM_OFF_TIME: begin
                    time_r <= clamp14(pwdata[13:0], `WM_TIME_MIN, `WM_TIME_MAX);
                end
                `WM_OFF_ENERGY: begin
                    energy_r <= clamp14(pwdata[13:0], `WM_ENERGY_MIN, `WM_ENERGY_MAX);
                end
                `WM_OFF_AMPL: begin
                    ampl_r <= clamp14(pwdata[13:0], 14'h0000, `WM_AMPL_RST);
                end
                `WM_OFF_CUTOFF: begin
                    cutoff_en_r <= pwdata[0];
                end
                default: begin
                    cutoff_en_r <= cutoff_en_r;
                end
            endcase
        end
    end

    // Panel key handling; keys are one-cycle pulses and up wins over down except at the upper limit, where down steps.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pnl_r <= PNL_BROWSE;
            sel_r <= `WM_REG_FIRST;
            pend_r <= 14'h0000;
        end else begin
            case (pnl_r)
                PNL_BROWSE: begin
                    if (key_cfg) begin
                        // Only register 138 is backed here; others show zero.
                        pend_r <= (sel_r == `WM_REG_MODE) ? {12'h000, mode_r} : 14'h0000;
                        pnl_r <= PNL_EDIT;
                    end else if (key_up && sel_r != `WM_REG_LAST) begin
                        sel_r <= sel_r + 8'h01;
                    end else if (key_down && sel_r != `WM_REG_FIRST) begin
                        sel_r <= sel_r - 8'h01;
                    end
                end
                PNL_EDIT, PNL_PARAM: begin
                    if (key_cfg) begin
                        if (mode_commit && pend_mode == `WM_MODE_CONT) begin
                            pnl_r <= PNL_AMPL;
                        end else if (mode_commit) begin
                            // Load the chosen mode's parameter for editing.
                            pend_r <= (pend_mode == `WM_MODE_TIME) ? time_r : energy_r;
                            pnl_r <= PNL_PARAM;
                        end else begin
                            pnl_r <= PNL_BROWSE;
                        end
                    end else if (key_up && pend_r != `WM_VALUE_MAX) begin
                        pend_r <= pend_r + 14'h0001;
                    end else if (key_down && pend_r != 14'h0000) begin
                        pend_r <= pend_r - 14'h0001;
                    end
                end
                PNL_AMPL: begin
                    if (key_cfg) begin
                        pnl_r <= PNL_BROWSE;
                    end
                end
                default: begin
                    pnl_r <= PNL_BROWSE;
                end
            endcase
        end
    end

    // Display drive, registered so the panel sees glitch-free levels.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            disp_value <= 14'h0000;
            icon_num <= 1'b0;
            icon_circle <= 1'b0;
            icon_pct <= 1'b0;
            icon_cont <= 1'b0;
            icon_time <= 1'b0;
            icon_energy <= 1'b0;
        end else begin
            icon_num <= (pnl_r == PNL_BROWSE);
            icon_circle <= (pnl_r == PNL_EDIT);
            icon_pct <= (pnl_r == PNL_AMPL);
            icon_cont <= (pnl_r == PNL_AMPL);
            icon_time <= (pnl_r == PNL_PARAM) && (mode_r == `WM_MODE_TIME);
            icon_energy <= (pnl_r == PNL_PARAM) && (mode_r == `WM_MODE_ENERGY);
            case (pnl_r)
                PNL_BROWSE: begin
                    disp_value <= {6'h00, sel_r};
                end
                PNL_AMPL: begin
                    disp_value <= ampl_r;
                end
                default: begin
                    disp_value <= pend_r;
                end
            endcase
        end
    end

    // Delivery next state; a timed, energy or cutoff end holds DONE until start is released.
    always_comb begin
        ws_nxt = ws_r;
        case (ws_r)
            WS_IDLE: begin
                if (start_in && !cut) begin
                    ws_nxt = WS_WELD;
                end
            end
            WS_WELD: begin
                if (cut) begin
                    ws_nxt = WS_DONE;
                end else if (mode_r == `WM_MODE_CONT) begin
                    if (!start_in) begin
                        ws_nxt = WS_IDLE;
                    end
                end else if (mode_r == `WM_MODE_TIME) begin
                    if (tick && (ticks_r + 14'h0001) >= time_r) begin
                        ws_nxt = WS_DONE;
                    end
                end else if (joules_r >= energy_r) begin
                    ws_nxt = WS_DONE;
                end
            end
            WS_DONE: begin
                if (!start_in) begin
                    ws_nxt = WS_IDLE;
                end
            end
            default: begin
                ws_nxt = WS_IDLE;
            end
        endcase
    end

    // Delivery state and its registered outputs.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ws_r <= WS_IDLE;
            us_on <= 1'b0;
            weld_done <= 1'b0;
        end else begin
            ws_r <= ws_nxt;
            us_on <= (ws_nxt == WS_WELD);
            weld_done <= (ws_nxt == WS_DONE);
        end
    end

    // Time and energy measurement, cleared when a weld starts.
    // Power is taken in watts each cycle; a joule is counted per clock-rate watt-cycles.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ticks_r <= 14'h0000;
            joules_r <= 14'h0000;
            frac_r <= 25'h0000000;
        end else if (ws_r == WS_IDLE && ws_nxt == WS_WELD) begin
            ticks_r <= 14'h0000;
            joules_r <= 14'h0000;
            frac_r <= 25'h0000000;
        end else if (ws_r == WS_WELD) begin
            if (tick && ticks_r != 14'h3FFF) begin
                ticks_r <= ticks_r + 14'h0001;
            end
            if (frac_sum >= `WM_JOULE_CYCLES) begin
                frac_r <= frac_sum - `WM_JOULE_CYCLES;
                if (joules_r != 14'h3FFF) begin
                    joules_r <= joules_r + 14'h0001;
                end
            end else begin
                frac_r <= frac_sum;
            end
        end
    end

endmodule // weld_mode_sequencer

// ==== common/weld_params.svh ====
`ifndef WELD_PARAMS_SVH
`define WELD_PARAMS_SVH

// Clock rate and the weld-time tick derived from it.
`define WM_CLK_HZ 25000000
`define WM_TICK_MS 10
`define WM_TICK_CYCLES ((`WM_CLK_HZ / 1000) * `WM_TICK_MS)
// Cycles that make one joule per watt of delivered power.
`define WM_JOULE_CYCLES 25'h17D7840

// APB register byte offsets.
`define WM_OFF_MODE 8'h00
`define WM_OFF_TIME 8'h04
`define WM_OFF_ENERGY 8'h08
`define WM_OFF_AMPL 8'h0C
`define WM_OFF_STATUS 8'h10
`define WM_OFF_CUTOFF 8'h14
`define WM_OFF_JOULES 8'h18
`define WM_OFF_TICKS 8'h1C

// Status register field positions.
`define WM_ST_ACTIVE 0
`define WM_ST_DONE 1
`define WM_ST_MODE_LO 2

// Weld-mode encodings held in panel register 138.
`define WM_MODE_CONT 2'h0
`define WM_MODE_TIME 2'h1
`define WM_MODE_ENERGY 2'h2

// Reset values and limits; time is in 10 ms ticks, energy in joules.
`define WM_MODE_RST 2'h0
`define WM_TIME_RST 14'h0001
`define WM_TIME_MIN 14'h0001
`define WM_TIME_MAX 14'h0BB8
`define WM_ENERGY_RST 14'h01F4
`define WM_ENERGY_MIN 14'h000A
`define WM_ENERGY_MAX 14'h270F
`define WM_AMPL_RST 14'h0064
`define WM_VALUE_MAX 14'h270F

// Front-panel register numbers.
`define WM_REG_FIRST 8'h65
`define WM_REG_LAST 8'hC7
`define WM_REG_MODE 8'h8A

`endif

// ==== common/weld_pkg.sv ====
package weld_pkg;

    // Front-panel display and key-handling states.
    typedef enum logic [1:0] {
        PNL_BROWSE,
        PNL_EDIT,
        PNL_PARAM,
        PNL_AMPL
    } panel_state_t;

    // Ultrasonic delivery states.
    typedef enum logic [1:0] {
        WS_IDLE,
        WS_WELD,
        WS_DONE
    } weld_state_t;

endpackage

// ==== hw/weld_tick_gen.sv ====
`timescale 1ns/10ps
// Emits a one-cycle tick every CYCLES clocks while run is high.
module weld_tick_gen #(
    parameter int CYCLES = 250000
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic run,
    output logic tick
);

    // Restarting from zero on every run keeps the first tick a full period after weld start.
    logic [31:0] cnt_r;

    // Cycle counter, held at zero while idle.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_r <= 32'h00000000;
            tick <= 1'b0;
        end else if (!run) begin
            cnt_r <= 32'h00000000;
            tick <= 1'b0;
        end else if (cnt_r == 32'(CYCLES - 1)) begin
            cnt_r <= 32'h00000000;
            tick <= 1'b1;
        end else begin
            cnt_r <= cnt_r + 32'h00000001;
            tick <= 1'b0;
        end
    end

endmodule // weld_tick_gen

// ==== verification/weld_operator_model.sv ====
`timescale 1ns/10ps
// Operator panel and automation start line as seen by the sequencer.
module weld_operator_model (
    input wire logic pclk,
    output logic key_up,
    output logic key_down,
    output logic key_cfg,
    output logic start_in
);
    // Start is low from power-up; the first edge, inside reset, settles every key low.
    initial begin
        set_start(1'b0);
        press(2'h3);
    end

    // One press is a single-cycle pulse; 0 is up, 1 is down, 2 is config, 3 is none.
    // The idle gap lets the display catch up before the next key.
    task automatic press(input logic [1:0] k);
        @(posedge pclk);
        key_up <= (k == 2'h0);
        key_down <= (k == 2'h1);
        key_cfg <= (k == 2'h2);
        @(posedge pclk);
        key_up <= 1'b0;
        key_down <= 1'b0;
        key_cfg <= 1'b0;
        repeat (3) @(posedge pclk);
    endtask

    // Called just after a rising edge, so the level changes off the sampling edge.
    task automatic set_start(input logic v);
        start_in <= v;
    endtask
endmodule // weld_operator_model

// ==== verification/weld_mode_sequencer_monitor.sv ====
`timescale 1ns/10ps
// Port-level timing checks for the weld mode sequencer.
module weld_mode_sequencer_monitor (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic key_up,
    input wire logic key_down,
    input wire logic key_cfg,
    input wire logic start_in,
    input wire logic cutoff_in,
    input wire logic us_on,
    input wire logic weld_done,
    input wire logic [13:0] disp_value,
    input wire logic icon_num,
    input wire logic icon_circle,
    input wire logic icon_cont
);
    logic cut_en_r; // Mirror of the cutoff enable bit, only the bus can set it.

    // Track bus writes to the cutoff enable word so cutoff checks know when to apply.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cut_en_r <= 1'b0;
        end else if (psel && penable && pready && pwrite && paddr == 8'h14) begin
            cut_en_r <= pwdata[0];
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_reset_browse: assert property ($rose(presetn) |=> icon_num && disp_value == 14'h0065)
        else $error("display not on first register after reset");
    a_browse_step: assert property (icon_num && key_up && !key_cfg && disp_value != 14'h00C7
        && !$past(key_up) && !$past(key_down) && !$past(key_cfg)
        |-> ##2 disp_value == $past(disp_value, 2) + 14'h0001)
        else $error("up key did not step the register number");
    a_cfg_opens: assert property (icon_num && key_cfg && !$past(key_cfg) |-> ##2 icon_circle)
        else $error("config key did not open the value view");
    a_edit_holds: assert property (icon_circle && !key_cfg && !$past(key_cfg) |-> ##2 icon_circle)
        else $error("value view left without config key");
    a_start_gates: assert property ($rose(us_on) |-> $past(start_in))
        else $error("output rose without start");
    a_done_quiet: assert property (weld_done |-> !us_on)
        else $error("output on while weld finished");
    a_done_holds: assert property (weld_done && start_in |=> weld_done)
        else $error("finished flag dropped while start held");
    a_cutoff_ends: assert property (cut_en_r && cutoff_in && us_on |-> ##[1:2] !us_on)
        else $error("cutoff did not end delivery");
    a_ready_next: assert property (psel && !penable |=> pready)
        else $error("no ready after setup");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("ready longer than one cycle");
    a_err_unmapped: assert property (psel && penable && pready && paddr > 8'h1C |-> pslverr)
        else $error("unmapped access without error");

    c_weld: cover property ($rose(us_on));
    c_done: cover property ($rose(weld_done));
    c_cont_view: cover property (icon_cont);
    c_err: cover property (pslverr);
endmodule // weld_mode_sequencer_monitor

bind weld_mode_sequencer weld_mode_sequencer_monitor i_mon (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .pready, .pslverr, .key_up, .key_down, .key_cfg, .start_in,
    .cutoff_in, .us_on, .weld_done, .disp_value, .icon_num, .icon_circle, .icon_cont);

// ==== verification/weld_mode_sequencer_tb.sv ====
`timescale 1ns/10ps
`include "weld_params.svh"
// Self-checking bench: bus registers, panel walk and weld timing per mode.
module weld_mode_sequencer_tb;
    localparam int TICKS = 10; // Short tick so timed welds last tens of cycles.
    logic pclk, presetn, psel, penable, pwrite, cutoff_in;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rdv;
    logic [31:0] lfsr = 32'h0000D1E6; // Fixed seed keeps every run the same.
    logic [15:0] power_w;
    logic pready, pslverr, key_up, key_down, key_cfg, start_in, err, done_seen;
    logic us_on, weld_done, icon_num, icon_circle, icon_pct, icon_cont, icon_time, icon_energy;
    logic [13:0] disp_value;
    int miscompares = 0, comparisons = 0, cnt, n, k;

    weld_mode_sequencer #(.TICK_CYCLES(TICKS)) i_dut (.pclk, .presetn, .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata, .pready, .pslverr, .key_up, .key_down, .key_cfg, .start_in,
        .cutoff_in, .power_w, .us_on, .weld_done, .disp_value, .icon_num, .icon_circle,
        .icon_pct, .icon_cont, .icon_time, .icon_energy);
    weld_operator_model i_op (.pclk, .key_up, .key_down, .key_cfg, .start_in);

    // Free-running 25 MHz clock.
    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end

    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic logic [31:0] clamp(input logic [31:0] v, input int lo, input int hi);
        return (v < lo) ? 32'(lo) : ((v > hi) ? 32'(hi) : v);
    endfunction
    // Cycles for a dose at constant power, rounded up: a joule is one watt-second.
    function automatic int energy_cycles(input longint j, input longint w);
        return int'((j * 25000000 + w - 1) / w);
    endfunction

    task automatic end_of_test();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            miscompares++;
            $display("unexpected %0s: expected %0h seen %0h", what, e, g);
        end
    endtask
    task automatic near(input string what, input int e, input int g, input int tol);
        comparisons++;
        if (g < e - tol || g > e + tol) begin
            miscompares++;
            $display("unexpected %0s: expected %0d seen %0d", what, e, g);
        end
    endtask
    // One bus transfer; ready and the answer are taken at the same rising edge.
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (k = 0; k < 20; k++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        if (k == 20) begin
            miscompares++;
            end_of_test();
        end
        rdv = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h00000000);
        chk($sformatf("register %0h", a), e, rdv);
    endtask
    task automatic wrrd(input logic [7:0] a, input logic [31:0] d, input logic [31:0] e);
        apb(1'b1, a, d);
        rd(a, e);
    endtask
    // Holds start until cycle hold, raises cutoff at cycle cut, counts output cycles.
    task automatic weld(input int hold, input int cut);
        cnt = 0;
        @(posedge pclk);
        i_op.set_start(1'b1);
        for (n = 1; n < 6000; n++) begin
            @(negedge pclk);
            if (us_on === 1'b1) cnt++;
            else if (cnt > 0) break;
            @(posedge pclk);
            if (n == hold) i_op.set_start(1'b0);
            if (n == cut) cutoff_in <= 1'b1;
        end
        done_seen = weld_done;
        if (n == 6000) begin
            miscompares++;
            end_of_test();
        end
        @(posedge pclk);
        i_op.set_start(1'b0);
        cutoff_in <= 1'b0;
        repeat (3) @(posedge pclk);
    endtask

    // Hard stop should anything hang.
    initial begin
        repeat (100000) @(posedge pclk);
        miscompares++;
        end_of_test();
    end

    initial begin
        presetn <= 1'b0;
        {psel, penable, cutoff_in} <= 3'h0;
        {pwrite, paddr, pwdata, power_w} <= {lfsr[0], lfsr[7:0], lfsr, lfsr[15:0]};
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        repeat (2) @(posedge pclk);
        chk("power-up register", 32'h65, 32'(disp_value));
        chk("number icon", 32'h1, 32'(icon_num));
        rd(`WM_OFF_MODE, 32'h0);
        rd(`WM_OFF_TIME, 32'h1);
        rd(`WM_OFF_ENERGY, 32'h1F4);
        apb(1'b0, 8'h20, 32'h00000000);
        chk("unmapped error", 32'h1, 32'(err));
        $display("test reset finished");
        // Walk the panel to register 138 and pick time mode, then continuous, then energy.
        for (int i = 0; i < 37; i++) i_op.press(2'h0);
        chk("selected register", 32'h8A, 32'(disp_value));
        i_op.press(2'h2);
        chk("value icon", 32'h1, 32'(icon_circle));
        chk("mode value", 32'h0, 32'(disp_value));
        i_op.press(2'h0);
        rd(`WM_OFF_MODE, 32'h0);
        i_op.press(2'h2);
        chk("time icon", 32'h1, 32'(icon_time));
        rd(`WM_OFF_MODE, 32'h1);
        for (int i = 0; i < 4; i++) i_op.press(2'h0);
        chk("pending time", 32'h5, 32'(disp_value));
        i_op.press(2'h2);
        rd(`WM_OFF_TIME, 32'h5);
        i_op.press(2'h2);
        i_op.press(2'h1);
        i_op.press(2'h2);
        chk("continuous icon", 32'h1, 32'(icon_cont));
        chk("amplitude shown", 32'h64, 32'(disp_value));
        chk("percent icon", 32'h1, 32'(icon_pct));
        i_op.press(2'h2);
        i_op.press(2'h2);
        i_op.press(2'h0);
        i_op.press(2'h0);
        i_op.press(2'h2);
        chk("energy icon", 32'h1, 32'(icon_energy));
        i_op.press(2'h2);
        $display("test panel finished");
        // Out-of-range writes land on the limits.
        wrrd(`WM_OFF_TIME, 32'h0000FFFF, 32'(`WM_TIME_MAX));
        wrrd(`WM_OFF_TIME, 32'h00000000, 32'(`WM_TIME_MIN));
        wrrd(`WM_OFF_ENERGY, 32'h00000005, 32'(`WM_ENERGY_MIN));
        wrrd(`WM_OFF_ENERGY, 32'h0000FFFF, 32'(`WM_ENERGY_MAX));
        wrrd(`WM_OFF_MODE, 32'h00000003, 32'(`WM_MODE_ENERGY));
        for (int i = 0; i < 4; i++) begin
            lfsr = lfsr_next(lfsr);
            wrrd(`WM_OFF_AMPL, {24'h000000, lfsr[7:0]}, clamp({24'h000000, lfsr[7:0]}, 0, 100));
        end
        $display("test limits finished");
        // Continuous mode: output length must equal the start pulse, whatever the power.
        apb(1'b1, `WM_OFF_MODE, 32'h0);
        for (int i = 0; i < 3; i++) begin
            lfsr = lfsr_next(lfsr);
            power_w <= lfsr[15:0];
            weld(2 + int'(lfsr[5:0]), 99999);
            near("continuous length", 2 + int'(lfsr[5:0]), cnt, 0);
            chk("continuous done", 32'h0, 32'(done_seen));
        end
        $display("test continuous finished");
        apb(1'b1, `WM_OFF_TIME, 32'h5);
        apb(1'b1, `WM_OFF_MODE, 32'h1);
        weld(99999, 99999);
        near("timed length", 5 * TICKS, cnt, 2);
        chk("timed done", 32'h1, 32'(done_seen));
        $display("test time finished");
        apb(1'b1, `WM_OFF_ENERGY, 32'hA);
        apb(1'b1, `WM_OFF_MODE, 32'h2);
        power_w <= 16'hFFFF;
        weld(99999, 99999);
        near("energy length", energy_cycles(10, 65535), cnt, 3);
        rd(`WM_OFF_JOULES, 32'hA);
        $display("test energy finished");
        apb(1'b1, `WM_OFF_CUTOFF, 32'h1);
        apb(1'b1, `WM_OFF_MODE, 32'h1);
        apb(1'b1, `WM_OFF_TIME, 32'hBB8);
        weld(99999, 20);
        near("cutoff length", 20, cnt, 2);
        chk("cutoff done", 32'h1, 32'(done_seen));
        rd(`WM_OFF_STATUS, 32'h4);
        $display("test cutoff finished");
        end_of_test();
    end
endmodule // weld_mode_sequencer_tb
